// [rtl/srr_top.sv]
// Status reporting register bank: operating and fault condition, event and mask
// registers, status byte summary bits, bus address setting and output enable.
// Assumes commands arrive from logic on clk; condition pins are asynchronous.
`timescale 1ns/1ps

module srr_top
    import srr_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic     clk,
    input  wire logic     nrst,
    input  wire logic     ce,

    // Asynchronous condition pins.
    input  wire srr_pin_s pins,

    // Command port and its answer.
    input  wire srr_cmd_s cmd,
    output srr_rsp_s      rsp,

    // Status and settings.
    output logic [7:0]    status_byte,
    output logic [4:0]    bus_address_setting,
    output logic          output_on
);

    srr_state_s r;
    srr_state_s next_r;

    // Maps operating condition pins to their register positions.
    function automatic logic [DW-1:0] oper_map(input srr_pin_s p);
        logic [DW-1:0] v;
        v = '0;
        v[OP_CAL_BIT] = p.cal;
        v[OP_WAIT_TRIGGER_BIT]  = p.wait_trigger_state;
        v[OP_CONST_VOLTAGE_BIT] = p.constant_voltage_state;
        v[OP_CONST_CURRENT_BIT] = p.constant_current_state;
        return v;
    endfunction

    // Maps fault condition pins to their register positions.
    function automatic logic [DW-1:0] flt_map(input srr_pin_s p);
        logic [DW-1:0] v;
        v = '0;
        v[FLT_OVERVOLTAGE_BIT]  = p.fault[0];
        v[FLT_OVERCURRENT_BIT]  = p.fault[1];
        v[FLT_OUTPUT_LEAD_BIT]  = p.fault[2];
        v[FLT_OVERTEMP_BIT]     = p.fault[3];
        v[FLT_POWER_LOSS_BIT]   = p.fault[4];
        v[FLT_FAN_BIT]          = p.fault[5];
        v[FLT_MASTER_SLAVE_BIT] = p.fault[6];
        return v;
    endfunction

    // Summary of one group: any event bit that its mask lets through.
    function automatic logic summary(input logic [DW-1:0] ev,
                                     input logic [DW-1:0] mask);
        return |(ev & mask);
    endfunction

    logic [DW-1:0] oper_now;
    logic [DW-1:0] oper_was;
    logic [DW-1:0] flt_now;
    logic [DW-1:0] flt_was;
    logic [DW-1:0] oper_set;
    logic [DW-1:0] flt_set;
    logic          oper_clr;
    logic          flt_clr;
    logic [4:0]    addr_in;

    always_comb begin
        next_r = r;

        // Three stage synchroniser; each pin's level is taken only once its stages
        // two and three agree, so a glitching pin never holds back the others.
        next_r.s1 = pins;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < $bits(srr_pin_s); i++) begin
            if (r.s2[i] == r.s3[i]) begin
                next_r.cond[i] = r.s2[i];
            end
        end

        oper_now = oper_map(next_r.cond);
        oper_was = oper_map(r.cond);
        flt_now  = flt_map(next_r.cond);
        flt_was  = flt_map(r.cond);

        // Events are rising edges of the filtered conditions.
        oper_set = oper_now & ~oper_was;
        flt_set  = flt_now & ~flt_was;

        // Continuous triggering re-arms the wait-for-trigger event every cycle.
        if (next_r.cond.cont_trig) begin
            oper_set[OP_WAIT_TRIGGER_BIT] = 1'b1;
        end

        oper_clr = 1'b0;
        flt_clr  = 1'b0;
        addr_in  = cmd.data[4:0];

        next_r.rsp       = '0;
        next_r.rsp.valid = cmd.valid;

        if (cmd.valid) begin
            case (cmd.op)
                SRR_NOP: begin
                    next_r.rsp.data = '0;
                end
                SRR_RD_OP_COND: begin
                    next_r.rsp.data = oper_was;
                end
                SRR_WR_OP_MASK: begin
                    if ((cmd.data & ~OPER_VALID) == '0) begin
                        next_r.oper_mask = cmd.data;
                    end else begin
                        next_r.rsp.err = 1'b1;
                    end
                end
                SRR_RD_OP_MASK: begin
                    next_r.rsp.data = r.oper_mask;
                end
                SRR_RD_OP_EVENT: begin
                    next_r.rsp.data = r.oper_event;
                    oper_clr = 1'b1;
                end
                SRR_PRESET: begin
                    next_r.oper_mask = MASK_RESET;
                    next_r.flt_mask  = MASK_RESET;
                end
                SRR_RD_FLT_EVENT: begin
                    next_r.rsp.data = r.flt_event;
                    flt_clr = 1'b1;
                end
                SRR_RD_FLT_COND: begin
                    next_r.rsp.data = flt_was;
                end
                SRR_WR_FLT_MASK: begin
                    if ((cmd.data & ~FLT_VALID) == '0) begin
                        next_r.flt_mask = cmd.data;
                    end else begin
                        next_r.rsp.err = 1'b1;
                    end
                end
                SRR_RD_FLT_MASK: begin
                    next_r.rsp.data = r.flt_mask;
                end
                SRR_WR_ADDR: begin
                    if (cmd.data[DW-1:5] == '0 && addr_in >= ADDR_MIN
                        && addr_in <= ADDR_MAX) begin
                        next_r.addr = addr_in;
                    end else begin
                        next_r.rsp.err = 1'b1;
                    end
                end
                SRR_RD_ADDR: begin
                    next_r.rsp.data = {11'h000, r.addr};
                end
                SRR_OUT_ON: begin
                    next_r.out_on = 1'b1;
                end
                SRR_OUT_OFF: begin
                    next_r.out_on = 1'b0;
                end
                default: begin
                    next_r.rsp.err = 1'b1;
                end
            endcase
        end

        // A new event in the cycle of the clearing read survives the clear.
        if (oper_clr) begin
            next_r.oper_event = oper_set;
        end else begin
            next_r.oper_event = r.oper_event | oper_set;
        end
        if (flt_clr) begin
            next_r.flt_event = flt_set;
        end else begin
            next_r.flt_event = r.flt_event | flt_set;
        end

        // Overvoltage wins over an output-on command in the same cycle.
        if (flt_set[FLT_OVERVOLTAGE_BIT]) begin
            next_r.out_on = 1'b0;
        end

        // Summary bits are built from the next values so that they change on
        // the same edge as the events and masks; the byte stays registered.
        next_r.status_byte = 8'h00;
        next_r.status_byte[SUM_OPER_BIT] =
            summary(next_r.oper_event, next_r.oper_mask);
        next_r.status_byte[SUM_FLT_BIT] =
            summary(next_r.flt_event, next_r.flt_mask);
    end

    // The fault event latch comes out of reset holding the power-loss bit,
    // standing for the loss recorded when source power went away.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r            <= '0;
            r.flt_event  <= FLT_EVENT_RESET;
            r.oper_event <= OPER_EVENT_RESET;
            r.oper_mask  <= MASK_RESET;
            r.flt_mask   <= MASK_RESET;
            r.addr       <= ADDR_RESET;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign rsp                 = r.rsp;
    assign status_byte         = r.status_byte;
    assign bus_address_setting = r.addr;
    assign output_on           = r.out_on;

endmodule

// [pkg/srr_pkg.sv]
// Shared types and constants of the status reporting register bank.
// Assumes a single 250 MHz clock and a command source in the same clock domain.
package srr_pkg;

    localparam int DW = 16;

    // Operating condition bit positions.
    localparam int OP_CAL_BIT           = 0;
    localparam int OP_WAIT_TRIGGER_BIT  = 5;
    localparam int OP_CONST_VOLTAGE_BIT = 8;
    localparam int OP_CONST_CURRENT_BIT = 10;

    // Fault condition bit positions; bits 15 to 7 are unused.
    localparam int FLT_OVERVOLTAGE_BIT  = 0;
    localparam int FLT_OVERCURRENT_BIT  = 1;
    localparam int FLT_OUTPUT_LEAD_BIT  = 2;
    localparam int FLT_OVERTEMP_BIT     = 3;
    localparam int FLT_POWER_LOSS_BIT   = 4;
    localparam int FLT_FAN_BIT          = 5;
    localparam int FLT_MASTER_SLAVE_BIT = 6;

    // Summary bit positions in the status byte.
    localparam int SUM_OPER_BIT = 7;
    localparam int SUM_FLT_BIT  = 3;

    // Bits that the two masks can hold.
    localparam logic [DW-1:0] OPER_VALID = 16'h0521;
    localparam logic [DW-1:0] FLT_VALID  = 16'h007f;

    // Reset values.
    localparam logic [DW-1:0] OPER_EVENT_RESET = 16'h0000;
    localparam logic [DW-1:0] FLT_EVENT_RESET  = 16'h0010;
    localparam logic [DW-1:0] MASK_RESET       = 16'h0000;
    localparam logic [4:0]    ADDR_RESET       = 5'h06;

    // Legal bus address range.
    localparam logic [4:0] ADDR_MIN = 5'h01;
    localparam logic [4:0] ADDR_MAX = 5'h1e;

    typedef enum logic [3:0] {
        SRR_NOP          = 4'h0,
        SRR_RD_OP_COND   = 4'h1,
        SRR_WR_OP_MASK   = 4'h2,
        SRR_RD_OP_MASK   = 4'h3,
        SRR_RD_OP_EVENT  = 4'h4,
        SRR_PRESET       = 4'h5,
        SRR_RD_FLT_EVENT = 4'h6,
        SRR_RD_FLT_COND  = 4'h7,
        SRR_WR_FLT_MASK  = 4'h8,
        SRR_RD_FLT_MASK  = 4'h9,
        SRR_WR_ADDR      = 4'ha,
        SRR_RD_ADDR      = 4'hb,
        SRR_OUT_ON       = 4'hc,
        SRR_OUT_OFF      = 4'hd
    } srr_op_e;

    typedef struct packed {
        logic          valid;
        srr_op_e       op;
        logic [DW-1:0] data;
    } srr_cmd_s;

    typedef struct packed {
        logic          valid;
        logic          err;
        logic [DW-1:0] data;
    } srr_rsp_s;

    // Raw condition pins, fault group in the low seven bits.
    typedef struct packed {
        logic       cont_trig;
        logic       constant_current_state;
        logic       constant_voltage_state;
        logic       wait_trigger_state;
        logic       cal;
        logic [6:0] fault;
    } srr_pin_s;

    typedef struct packed {
        srr_pin_s      s1;
        srr_pin_s      s2;
        srr_pin_s      s3;
        srr_pin_s      cond;
        logic [DW-1:0] oper_event;
        logic [DW-1:0] oper_mask;
        logic [DW-1:0] flt_event;
        logic [DW-1:0] flt_mask;
        logic [4:0]    addr;
        logic          out_on;
        logic [7:0]    status_byte;
        srr_rsp_s      rsp;
    } srr_state_s;

endpackage

// [verification/srr_asserts.sv]
// Port assertions of the status register bank.
// Assumes a bind to srr_top with ce held high.
`timescale 1ns/1ps
module srr_asserts
    import srr_pkg::*;
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       nrst,
    // Inputs.
    input wire logic       ce,
    input wire srr_pin_s   pins,
    input wire srr_cmd_s   cmd,
    // Outputs.
    input wire srr_rsp_s   rsp,
    input wire logic [7:0] status_byte,
    input wire logic [4:0] bus_address_setting,
    input wire logic       output_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire take = ce && cmd.valid;

    a_rsp_answers: assert property (take |=> rsp.valid)
        else $error("no answer");
    a_rsp_pulse: assert property (!take |=> !rsp.valid)
        else $error("stray answer");
    a_status_unused: assert property ((status_byte & 8'h77) == 8'h00)
        else $error("unused status bit set");
    a_preset_clear: assert property (take && cmd.op == SRR_PRESET |=>
        status_byte[7] == 1'b0 && status_byte[3] == 1'b0) else $error("summary after preset");
    a_mask_refuse: assert property (take && cmd.op == SRR_WR_OP_MASK &&
        (cmd.data & ~OPER_VALID) != 16'h0000 |=> rsp.err) else $error("bad mask taken");
    a_addr_range: assert property (bus_address_setting inside {[ADDR_MIN:ADDR_MAX]})
        else $error("address out of range");
    a_addr_store: assert property (take && cmd.op == SRR_WR_ADDR &&
        cmd.data inside {[16'h0001:16'h001e]} |=>
        bus_address_setting == $past(cmd.data[4:0]) && !rsp.err) else $error("address lost");
    // Five quiet samples first, so the glitch filter has surely seen the pin low.
    a_overvoltage_off: assert property (!pins.fault[0] [*5] ##1 pins.fault[0] [*5] |->
        !output_on) else $error("output on in overvoltage");

    c_preset: cover property (take && cmd.op == SRR_PRESET);
    c_output_trip: cover property ($fell(output_on));
    c_refuse: cover property (rsp.valid && rsp.err);
endmodule

// [verification/srr_host.sv]
// Host model: one command at a time, answer taken in its only cycle.
// Assumes the bank registers its answer on the taking edge, read 1 ns later.
`timescale 1ns/1ps
module srr_host
    import srr_pkg::*;
(
    // Clock.
    input  wire logic     clk,
    // Command port and answer.
    output srr_cmd_s      cmd,
    input  wire srr_rsp_s rsp
);
    initial cmd = '0;

    // Values go out as given, so that the bench can provoke refusals.
    task automatic xfer(input logic [3:0] op, input logic [15:0] d,
                        output srr_rsp_s r);
        @(posedge clk);
        #1 cmd = {1'b1, srr_op_e'(op), d};
        @(posedge clk);
        #1 cmd.valid = 1'b0;
        r = rsp;
    endtask
endmodule

// [verification/srr_top_bench.sv]
// Self-checking bench of the status register bank.
// Assumes a 250 MHz clock; ce is held high.
`timescale 1ns/1ps
module srr_top_bench
    import srr_pkg::*;
;
    typedef struct packed {
        logic [3:0]  op;
        logic [15:0] d;
        logic        e;
        logic [15:0] q;
    } srr_row_s;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    srr_pin_s   pins = '0;
    srr_cmd_s   cmd;
    srr_rsp_s   rsp;
    srr_rsp_s   r;
    logic [7:0] status_byte;
    logic [4:0] bus_address_setting;
    logic       output_on;
    int         miscompares = 0;
    int         comparisons = 0;
    int         cycles = 0;
    srr_row_s   rows [16] = '{
        '{4'h6, 16'h0000, 1'b0, 16'h0010},
        '{4'h6, 16'h0000, 1'b0, 16'h0000},
        '{4'h2, 16'h0521, 1'b0, 16'h0000},
        '{4'h3, 16'h0000, 1'b0, 16'h0521},
        '{4'h2, 16'h0522, 1'b1, 16'h0000},
        '{4'h3, 16'h0000, 1'b0, 16'h0521},
        '{4'h8, 16'h0080, 1'b1, 16'h0000},
        '{4'h8, 16'h0003, 1'b0, 16'h0000},
        '{4'h9, 16'h0000, 1'b0, 16'h0003},
        '{4'ha, 16'h001f, 1'b1, 16'h0000},
        '{4'ha, 16'h0000, 1'b1, 16'h0000},
        '{4'ha, 16'h001e, 1'b0, 16'h0000},
        '{4'hb, 16'h0000, 1'b0, 16'h001e},
        '{4'h0, 16'h0000, 1'b0, 16'h0000},
        '{4'he, 16'h0000, 1'b1, 16'h0000},
        '{4'hf, 16'h0123, 1'b1, 16'h0000}
    };

    always #2 clk = ~clk;

    srr_top dut (.clk(clk), .nrst(nrst), .ce(1'b1), .pins(pins), .cmd(cmd), .rsp(rsp),
        .status_byte(status_byte), .bus_address_setting(bus_address_setting),
        .output_on(output_on));
    srr_host host (.clk(clk), .cmd(cmd), .rsp(rsp));

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_rsp(input srr_rsp_s exp);
        comparisons++;
        if (r !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: answer %h, expected %h", $time, r, exp);
        end
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [3:0] op, input logic [15:0] d, input logic e,
                       input logic [15:0] q);
        host.xfer(op, d, r);
        chk_rsp({1'b1, e, q});
    endtask

    // Six edges cover the three-stage pin synchroniser and filter with margin.
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].d, rows[i].e, rows[i].q);
        end
        pins.constant_voltage_state = 1'b1;
        pins.constant_current_state = 1'b1;
        settle();
        run(4'h1, 16'h0000, 1'b0, 16'h0500);
        chk_out(status_byte, 8'h80);
        run(4'h4, 16'h0000, 1'b0, 16'h0500);
        pins.constant_voltage_state = 1'b0;
        pins.constant_current_state = 1'b0;
        settle();
        run(4'h1, 16'h0000, 1'b0, 16'h0000);
        run(4'h4, 16'h0000, 1'b0, 16'h0000);
        chk_out(status_byte, 8'h00);
        pins.cont_trig = 1'b1;
        settle();
        run(4'h4, 16'h0000, 1'b0, 16'h0020);
        run(4'h4, 16'h0000, 1'b0, 16'h0020);
        chk_out(status_byte, 8'h80);
        pins.cont_trig = 1'b0;
        run(4'hc, 16'h0000, 1'b0, 16'h0000);
        chk_out({7'h00, output_on}, 8'h01);
        pins.fault[0] = 1'b1;
        settle();
        chk_out({7'h00, output_on}, 8'h00);
        chk_out(status_byte & 8'h08, 8'h08);
        run(4'h7, 16'h0000, 1'b0, 16'h0001);
        run(4'h6, 16'h0000, 1'b0, 16'h0001);
        run(4'h6, 16'h0000, 1'b0, 16'h0000);
        run(4'h5, 16'h0000, 1'b0, 16'h0000);
        run(4'h9, 16'h0000, 1'b0, 16'h0000);
        run(4'h3, 16'h0000, 1'b0, 16'h0000);
        chk_out(status_byte, 8'h00);
        pins.fault[0] = 1'b0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        chk_out({3'h0, bus_address_setting}, {3'h0, ADDR_RESET});
        chk_out(status_byte, 8'h00);
        run(4'h6, 16'h0000, 1'b0, 16'h0010);
        run(4'hc, 16'h0000, 1'b0, 16'h0000);
        chk_out({7'h00, output_on}, 8'h01);
        run(4'hd, 16'h0000, 1'b0, 16'h0000);
        chk_out({7'h00, output_on}, 8'h00);
        test_done();
    end
endmodule

bind srr_top srr_asserts chk (.clk(clk), .nrst(nrst), .ce(ce), .pins(pins), .cmd(cmd),
    .rsp(rsp), .status_byte(status_byte), .bus_address_setting(bus_address_setting),
    .output_on(output_on));
